// File: inc/weekday_clock_timer_pkg.sv
// Constants shared by the weekday clock timer and its sub-blocks.
package weekday_clock_timer_pkg;

	// Width of the control and peripheral address ports.
	localparam int ADDR_W = 7;
	// Width of the control register data and of the transfer buffer.
	localparam int CTRL_W = 4;
	localparam int BUF_W = 8;
	// Number of time counters in the cascade.
	localparam int NUM_COUNTERS = 4;

	// Control register addresses.
	localparam logic [ADDR_W-1:0] MODE_ADDR = 7'h06;
	localparam logic [ADDR_W-1:0] RESET_FLAGS_ADDR = 7'h07;
	localparam logic [ADDR_W-1:0] FAST_CARRY_ADDR = 7'h1E;
	localparam logic [ADDR_W-1:0] SLOW_CARRY_ADDR = 7'h1F;

	// Peripheral addresses of the counters, seconds in entry 0.
	localparam logic [NUM_COUNTERS-1:0][ADDR_W-1:0] COUNT_ADDR =
		{7'h1D, 7'h1C, 7'h1B, 7'h1A};
	// Last legal value of each counter, seconds in entry 0.
	localparam logic [NUM_COUNTERS-1:0][BUF_W-1:0] COUNT_LAST =
		{8'h06, 8'h17, 8'h3B, 8'h3B};

	// Bit positions in the mode and carry registers.
	localparam int OSC_SEL_BIT = 0;
	localparam int ADJ_OUT_BIT = 1;
	localparam int HOLD_BIT = 3;
	localparam int CARRY_BIT = 0;

	// Reset values of the control state.
	localparam logic [CTRL_W-1:0] MODE_RESET = 4'h0;
	localparam logic [CTRL_W-1:0] FLAGS_RESET = 4'h0;
	localparam logic [BUF_W-1:0] COUNT_RESET = 8'h00;

	// Oscillator rate and the divided rates, in Hz.
	localparam int OSC_HZ = 32768;
	localparam int FAST_HZ = 128;
	localparam int SLOW_HZ = 8;
	// Point within each second at which the hold freezes the divider, in ms.
	localparam int HOLD_MS = 500;

endpackage

// File: verilog/clock_divider.sv
// Oscillator divider producing the 128 Hz, 8 Hz and one second ticks.
`timescale 1ns/1ps
module clock_divider
	import weekday_clock_timer_pkg::*;
#(
	parameter int OSC_RATE = OSC_HZ
)
(
	// Clock and reset.
	input wire logic clock_in,
	input wire logic nrst_in,
	// Oscillator edge and hold control.
	input wire logic osc_edge_in,
	input wire logic hold_in,
	// Divided ticks, one cycle each.
	output logic fast_tick_out,
	output logic slow_tick_out,
	output logic second_tick_out
);
	// Counter width covering one full second of oscillator edges.
	localparam int DIV_W = $clog2(OSC_RATE);
	// Oscillator edges per fast and per slow carry.
	localparam int FAST_DIV = OSC_RATE / FAST_HZ;
	localparam int SLOW_DIV = OSC_RATE / SLOW_HZ;
	// Count at which half a second of division is complete.
	localparam logic [DIV_W-1:0] HOLD_POINT =
		DIV_W'(OSC_RATE * HOLD_MS / 1000 - 1);

	// All divider state.
	typedef struct packed {
		logic [DIV_W-1:0] count;
		logic fast;
		logic slow;
		logic second;
	} div_state_type;

	div_state_type st_ff;
	div_state_type nxt_st;

	// Advance on each oscillator edge unless frozen at the hold point.
	always_comb
	begin
		nxt_st = st_ff;
		nxt_st.fast = 1'b0;
		nxt_st.slow = 1'b0;
		nxt_st.second = 1'b0;
		if (osc_edge_in && !(hold_in && st_ff.count == HOLD_POINT))
		begin
			// Carries are taken from the count that is being left.
			nxt_st.fast = (int'(st_ff.count) % FAST_DIV) == FAST_DIV - 1;
			nxt_st.slow = (int'(st_ff.count) % SLOW_DIV) == SLOW_DIV - 1;
			nxt_st.second = int'(st_ff.count) == OSC_RATE - 1;
			nxt_st.count = DIV_W'(st_ff.count + 1'b1);
		end
	end

	// State register.
	always_ff @(posedge clock_in or negedge nrst_in)
	begin
		if (!nrst_in)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end

	assign fast_tick_out = st_ff.fast;
	assign slow_tick_out = st_ff.slow;
	assign second_tick_out = st_ff.second;

	// A held divider stays at the half second point.
	property p_hold_freeze;
		@(posedge clock_in) disable iff (!nrst_in)
		hold_in && st_ff.count == HOLD_POINT |=>
			st_ff.count == HOLD_POINT && !st_ff.second;
	endproperty
	a_hold_freeze: assert property (p_hold_freeze)
		else $error("Divider moved while held at the half second point.");

endmodule

// File: verilog/time_counter.sv
// One modulo time counter with clear, load and carry.
`timescale 1ns/1ps
module time_counter
	import weekday_clock_timer_pkg::*;
#(
	parameter int WIDTH = BUF_W,
	parameter logic [WIDTH-1:0] LAST = WIDTH'(59)
)
(
	// Clock and reset.
	input wire logic clock_in,
	input wire logic nrst_in,
	// Control from the register side.
	input wire logic clear_in,
	input wire logic load_in,
	input wire logic [WIDTH-1:0] load_value_in,
	// Count step from the previous stage.
	input wire logic step_in,
	// Count and wrap carry.
	output logic [WIDTH-1:0] count_out,
	output logic carry_out
);
	// All counter state.
	typedef struct packed {
		logic [WIDTH-1:0] count;
	} cnt_state_type;

	cnt_state_type st_ff;
	cnt_state_type nxt_st;

	// Clear beats load, load beats counting.
	always_comb
	begin
		nxt_st = st_ff;
		if (clear_in)
			nxt_st.count = '0;
		else if (load_in)
			nxt_st.count = load_value_in;
		else if (step_in)
		begin
			// An illegal value keeps incrementing; its content is undefined.
			if (st_ff.count == LAST)
				nxt_st.count = '0;
			else
				nxt_st.count = WIDTH'(st_ff.count + 1'b1);
		end
	end

	// State register.
	always_ff @(posedge clock_in or negedge nrst_in)
	begin
		if (!nrst_in)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end

	assign count_out = st_ff.count;
	// A held or reloaded counter gives no carry.
	assign carry_out = step_in && !clear_in && !load_in && st_ff.count == LAST;

endmodule

// File: verilog/weekday_clock_timer.sv
// Weekday clock timer: divider, counter cascade and register access.
// How it works
// - Divide oscillator to a second tick driving counters.
// - Divider sets carry flags at 128 and 8 Hz.
// - Fast carry reads in bit 0, read clears it.
// - Slow carry register behaves like the fast one.
// - Hold freezes divider at its half second point.
// - Hold is mode register bit 3 at 06H.
// - Mode bit 0 selects oscillator or port pins.
// - Mode bit 1 enables adjustment clock output pin.
// - Four 8-bit counters: 60, 60, 24, 7.
// - Seconds and minutes count 0..59 with carry.
// - Hours count 0..23, carry every 24 hours.
// - Days count 0..6, wrapping every seven days.
// - Out of range writes leave undefined content.
// - Counters read and written through transfer buffer.
// - Reset flags bits 0..3 hold counters at zero.
`timescale 1ns/1ps
module weekday_clock_timer
	import weekday_clock_timer_pkg::*;
#(
	parameter int OSC_RATE = OSC_HZ
)
(
	// Clock and reset.
	input wire logic clock_in,
	input wire logic nrst_in,
	// Oscillator clock from its pin.
	input wire logic osc_32k_in,
	// Control register port, 4 bits.
	input wire logic [ADDR_W-1:0] ctrl_addr_in,
	input wire logic ctrl_wr_in,
	input wire logic ctrl_rd_in,
	input wire logic [CTRL_W-1:0] ctrl_wdata_in,
	output logic [CTRL_W-1:0] ctrl_rdata_out,
	// Peripheral port through the transfer buffer, 8 bits.
	input wire logic [ADDR_W-1:0] periph_addr_in,
	input wire logic put_in,
	input wire logic get_in,
	input wire logic [BUF_W-1:0] transfer_buffer_in,
	output logic [BUF_W-1:0] transfer_buffer_out,
	// Pin functions.
	output logic osc_pin_select_out,
	output logic adjust_clock_pin_out
);
	// All register side state.
	typedef struct packed {
		logic osc_sync1;
		logic osc_sync2;
		logic osc_prev;
		logic osc_pin_select;
		logic adjust_clock_out_enable;
		logic divider_hold;
		logic [NUM_COUNTERS-1:0] counter_reset_flag;
		logic fast_carry_flag;
		logic slow_carry_flag;
		logic [CTRL_W-1:0] ctrl_rdata;
		logic [BUF_W-1:0] buf_rdata;
		logic adjust_pin;
	} top_state_type;

	top_state_type st_ff;
	top_state_type nxt_st;

	// Oscillator edge, only seen while the pins carry the oscillator.
	logic osc_edge;
	// Divider ticks.
	logic fast_tick;
	logic slow_tick;
	logic second_tick;
	// Counter values, steps, loads and carries, seconds in entry 0.
	logic [NUM_COUNTERS-1:0][BUF_W-1:0] count;
	logic [NUM_COUNTERS-1:0] step;
	logic [NUM_COUNTERS-1:0] load;
	logic [NUM_COUNTERS-1:0] carry;
	// Decoded control accesses.
	logic wr_mode;
	logic wr_flags;
	logic rd_fast;
	logic rd_slow;

	// The divider only sees edges when the oscillator pins are selected.
	assign osc_edge = st_ff.osc_sync2 && !st_ff.osc_prev &&
		st_ff.osc_pin_select;

	// Divider with hold taken from the mode register.
	clock_divider #(
		.OSC_RATE(OSC_RATE)
	) i_clock_divider (
		.clock_in(clock_in),
		.nrst_in(nrst_in),
		.osc_edge_in(osc_edge),
		.hold_in(st_ff.divider_hold),
		.fast_tick_out(fast_tick),
		.slow_tick_out(slow_tick),
		.second_tick_out(second_tick)
	);

	// One counter per time unit, chained by their carries.
	genvar i;
	generate
		for (i = 0; i < NUM_COUNTERS; i++)
		begin : g_count
			if (i == 0)
			begin : g_first
				assign step[i] = second_tick;
			end
			else
			begin : g_next
				assign step[i] = carry[i-1];
			end
			// A put to the counter's own address loads it.
			assign load[i] = put_in && periph_addr_in == COUNT_ADDR[i];
			time_counter #(
				.WIDTH(BUF_W),
				.LAST(COUNT_LAST[i])
			) i_time_counter (
				.clock_in(clock_in),
				.nrst_in(nrst_in),
				.clear_in(st_ff.counter_reset_flag[i]),
				.load_in(load[i]),
				.load_value_in(transfer_buffer_in),
				.step_in(step[i]),
				.count_out(count[i]),
				.carry_out(carry[i])
			);
		end
	endgenerate

	// Control access decode.
	assign wr_mode = ctrl_wr_in && ctrl_addr_in == MODE_ADDR;
	assign wr_flags = ctrl_wr_in && ctrl_addr_in == RESET_FLAGS_ADDR;
	assign rd_fast = ctrl_rd_in && ctrl_addr_in == FAST_CARRY_ADDR;
	assign rd_slow = ctrl_rd_in && ctrl_addr_in == SLOW_CARRY_ADDR;

	// Next state of synchroniser, registers, flags and read data.
	always_comb
	begin
		nxt_st = st_ff;
		// The first stage feeds only the second stage.
		nxt_st.osc_sync1 = osc_32k_in;
		nxt_st.osc_sync2 = st_ff.osc_sync1;
		nxt_st.osc_prev = st_ff.osc_sync2;
		// Mode register write; bit 2 has no function.
		if (wr_mode)
		begin
			nxt_st.osc_pin_select = ctrl_wdata_in[OSC_SEL_BIT];
			nxt_st.adjust_clock_out_enable = ctrl_wdata_in[ADJ_OUT_BIT];
			nxt_st.divider_hold = ctrl_wdata_in[HOLD_BIT];
		end
		// Reset flag write, one bit per counter.
		if (wr_flags)
			nxt_st.counter_reset_flag = ctrl_wdata_in;
		// A new carry wins over the clear by a read in the same cycle.
		nxt_st.fast_carry_flag = fast_tick ||
			(st_ff.fast_carry_flag && !rd_fast);
		nxt_st.slow_carry_flag = slow_tick ||
			(st_ff.slow_carry_flag && !rd_slow);
		// Control read data, only bit 0 of the mode register reads back.
		if (ctrl_rd_in)
		begin
			nxt_st.ctrl_rdata = '0;
			if (ctrl_addr_in == MODE_ADDR)
				nxt_st.ctrl_rdata[OSC_SEL_BIT] = st_ff.osc_pin_select;
			else if (rd_fast)
				nxt_st.ctrl_rdata[CARRY_BIT] = st_ff.fast_carry_flag;
			else if (rd_slow)
				nxt_st.ctrl_rdata[CARRY_BIT] = st_ff.slow_carry_flag;
			else if (ctrl_addr_in == RESET_FLAGS_ADDR)
				nxt_st.ctrl_rdata = st_ff.counter_reset_flag;
		end
		// Counter read through the transfer buffer; unmapped reads zero.
		if (get_in)
		begin
			nxt_st.buf_rdata = '0;
			for (int k = 0; k < NUM_COUNTERS; k++)
			begin
				if (periph_addr_in == COUNT_ADDR[k])
					nxt_st.buf_rdata = count[k];
			end
		end
		// The synchronised oscillator goes out while enabled.
		nxt_st.adjust_pin = st_ff.osc_sync2 &&
			st_ff.adjust_clock_out_enable;
	end

	// State register with defined reset values.
	always_ff @(posedge clock_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			st_ff <= '0;
			st_ff.counter_reset_flag <= FLAGS_RESET;
		end
		else
			st_ff <= nxt_st;
	end

	// Outputs straight from the state register.
	assign ctrl_rdata_out = st_ff.ctrl_rdata;
	assign transfer_buffer_out = st_ff.buf_rdata;
	assign osc_pin_select_out = st_ff.osc_pin_select;
	assign adjust_clock_pin_out = st_ff.adjust_pin;

	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (!nrst_in);

	// A fast tick sets the fast carry flag.
	property p_fast_set;
		fast_tick |=> st_ff.fast_carry_flag;
	endproperty
	a_fast_set: assert property (p_fast_set)
		else $error("Fast carry flag not set by its tick.");

	// Reading the fast carry returns it and clears it.
	property p_fast_read;
		rd_fast && !fast_tick |=>
			!st_ff.fast_carry_flag &&
			ctrl_rdata_out[CARRY_BIT] == $past(st_ff.fast_carry_flag);
	endproperty
	a_fast_read: assert property (p_fast_read)
		else $error("Fast carry read did not report and clear.");

	// Reading the slow carry returns it and clears it.
	property p_slow_read;
		rd_slow && !slow_tick |=>
			!st_ff.slow_carry_flag &&
			ctrl_rdata_out == {3'h0, $past(st_ff.slow_carry_flag)};
	endproperty
	a_slow_read: assert property (p_slow_read)
		else $error("Slow carry read did not report and clear.");

	// Mode reads show only the pin select bit.
	property p_mode_read;
		ctrl_rd_in && ctrl_addr_in == MODE_ADDR |=>
			ctrl_rdata_out == {3'h0, $past(st_ff.osc_pin_select)};
	endproperty
	a_mode_read: assert property (p_mode_read)
		else $error("Mode register read returned more than bit 0.");

	// A disabled adjustment output stays low.
	property p_adjust_off;
		!st_ff.adjust_clock_out_enable |=> !adjust_clock_pin_out;
	endproperty
	a_adjust_off: assert property (p_adjust_off)
		else $error("Adjustment clock driven while disabled.");

	// A set days reset flag keeps the days counter at zero.
	property p_reset_hold;
		st_ff.counter_reset_flag[3] [*2] |-> count[3] == COUNT_RESET;
	endproperty
	a_reset_hold: assert property (p_reset_hold)
		else $error("Days counter moved while its reset flag was set.");

	// Seconds wrap from 59 to 0 and carry into minutes.
	property p_sec_wrap;
		step[0] && count[0] == COUNT_LAST[0] &&
			!st_ff.counter_reset_flag[0] && !load[0] |->
			carry[0] ##1 count[0] == COUNT_RESET;
	endproperty
	a_sec_wrap: assert property (p_sec_wrap)
		else $error("Seconds counter did not wrap with carry.");

	// Hours wrap from 23 to 0.
	property p_hour_wrap;
		step[2] && count[2] == COUNT_LAST[2] &&
			!st_ff.counter_reset_flag[2] && !load[2] |=>
			count[2] == COUNT_RESET;
	endproperty
	a_hour_wrap: assert property (p_hour_wrap)
		else $error("Hours counter did not wrap at 23.");

	// Days wrap from 6 to 0 without a further carry.
	property p_day_wrap;
		step[3] && count[3] == COUNT_LAST[3] &&
			!st_ff.counter_reset_flag[3] && !load[3] |=>
			count[3] == COUNT_RESET;
	endproperty
	a_day_wrap: assert property (p_day_wrap)
		else $error("Days counter did not wrap at 6.");

	// A minutes carry advances the hours by one.
	property p_cascade;
		carry[1] && count[2] < COUNT_LAST[2] &&
			!st_ff.counter_reset_flag[2] && !load[2] |=>
			count[2] == BUF_W'($past(count[2]) + 1'b1);
	endproperty
	a_cascade: assert property (p_cascade)
		else $error("Minutes carry did not advance the hours.");

endmodule

// File: tb/weekday_clock_timer_test.sv
// Self-checking testbench for the weekday clock timer.
`timescale 1ns/1ps
module weekday_clock_timer_test;
	import weekday_clock_timer_pkg::*;

	// Shortened oscillator rate; one oscillator edge every 16 clocks.
	localparam int RATE = 1024;
	localparam int SEC = RATE * 16;
	// Operation kinds understood by the driver task.
	localparam int IDLE = 0;
	localparam int WR = 1;
	localparam int RD = 2;
	localparam int PUT = 3;
	localparam int GET = 4;

	// Clock, reset and oscillator pin.
	logic clock_in = 1'b0;
	logic nrst_in = 1'b0;
	logic osc_32k_in = 1'b0;
	logic [2:0] osc_div = 3'h0;
	// Control port drives and answer.
	logic [ADDR_W-1:0] ctrl_addr_in = 7'h00;
	logic ctrl_wr_in = 1'b0;
	logic ctrl_rd_in = 1'b0;
	logic [CTRL_W-1:0] ctrl_wdata_in = 4'h0;
	logic [CTRL_W-1:0] ctrl_rdata_out;
	// Peripheral port drives and answer.
	logic [ADDR_W-1:0] periph_addr_in = 7'h00;
	logic put_in = 1'b0;
	logic get_in = 1'b0;
	logic [BUF_W-1:0] transfer_buffer_in = 8'h00;
	logic [BUF_W-1:0] transfer_buffer_out;
	// Pin function outputs.
	logic osc_pin_select_out;
	logic adjust_clock_pin_out;
	// Read strobes delayed one cycle mark when an answer is due.
	logic rd_q = 1'b0;
	logic get_q = 1'b0;
	// Expected answers in the order the reads were issued.
	logic [7:0] exp_q[$];
	// Result counters and random state.
	int miscompares = 0;
	int checked = 0;
	logic [31:0] seed = 32'h00000029;

	// Device under test with the shortened oscillator rate.
	weekday_clock_timer #(.OSC_RATE(RATE)) i_weekday_clock_timer (
		.clock_in(clock_in),
		.nrst_in(nrst_in),
		.osc_32k_in(osc_32k_in),
		.ctrl_addr_in(ctrl_addr_in),
		.ctrl_wr_in(ctrl_wr_in),
		.ctrl_rd_in(ctrl_rd_in),
		.ctrl_wdata_in(ctrl_wdata_in),
		.ctrl_rdata_out(ctrl_rdata_out),
		.periph_addr_in(periph_addr_in),
		.put_in(put_in),
		.get_in(get_in),
		.transfer_buffer_in(transfer_buffer_in),
		.transfer_buffer_out(transfer_buffer_out),
		.osc_pin_select_out(osc_pin_select_out),
		.adjust_clock_pin_out(adjust_clock_pin_out)
	);

	// System clock, 4 ns period.
	always #2 clock_in = ~clock_in;

	// Oscillator pin toggles every 8 clocks, unrelated to any access.
	always @(posedge clock_in)
	begin
		osc_div <= osc_div + 3'h1;
		if (osc_div == 3'h7)
			osc_32k_in <= ~osc_32k_in;
	end

	// Xorshift generator for counter load values.
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	// Compares one value and counts it; reports a mismatch at once.
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Prints the verdict and ends the run.
	task automatic final_report();
		if (miscompares == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// Drives one cycle of access; reads note their expected answer.
	task automatic op(input int kind, input logic [6:0] addr,
		input logic [7:0] data);
		@(posedge clock_in);
		ctrl_wr_in <= (kind == WR);
		ctrl_rd_in <= (kind == RD);
		put_in <= (kind == PUT);
		get_in <= (kind == GET);
		ctrl_addr_in <= addr;
		periph_addr_in <= addr;
		ctrl_wdata_in <= data[3:0];
		transfer_buffer_in <= data;
		if (kind == RD || kind == GET)
			exp_q.push_back(data);
	endtask

	// Lets cycles pass with all strobes low.
	task automatic idle(input int n);
		repeat (n) op(IDLE, 7'h00, 8'h00);
	endtask

	// Counts high samples of the adjustment pin over four oscillator periods.
	task automatic adj_ones(output int n);
		n = 0;
		repeat (64)
		begin
			@(negedge clock_in);
			n += (adjust_clock_pin_out === 1'b1);
		end
	endtask

	// Answer watcher: the oldest note is compared when an answer is due.
	always @(posedge clock_in)
	begin
		rd_q <= ctrl_rd_in;
		get_q <= get_in;
		if (rd_q && exp_q.size() > 0)
			check({4'h0, ctrl_rdata_out}, exp_q.pop_front());
		if (get_q && exp_q.size() > 0)
			check(transfer_buffer_out, exp_q.pop_front());
	end

	// Main sequence.
	initial
	begin
		logic [7:0] v;
		int n;
		repeat (16) @(posedge clock_in);
		nrst_in <= 1'b1;
		// Everything starts cleared; unmapped places read as zero.
		op(RD, MODE_ADDR, 8'h00);
		op(RD, RESET_FLAGS_ADDR, 8'h00);
		op(RD, FAST_CARRY_ADDR, 8'h00);
		op(RD, SLOW_CARRY_ADDR, 8'h00);
		op(RD, 7'h05, 8'h00);
		for (int i = 0; i < 5; i++)
			op(GET, 7'h1A + 7'(i), 8'h00);
		// Held counters refuse loads; released ones take random values.
		for (int i = 0; i < NUM_COUNTERS; i++)
		begin
			v = 8'(rnd() % (COUNT_LAST[i] + 1));
			op(WR, RESET_FLAGS_ADDR, 8'(1 << i));
			op(PUT, COUNT_ADDR[i], v);
			op(GET, COUNT_ADDR[i], 8'h00);
			op(WR, RESET_FLAGS_ADDR, 8'h00);
			op(PUT, COUNT_ADDR[i], v);
			op(GET, COUNT_ADDR[i], v);
		end
		// Clear all counters, then load each with its last legal value.
		op(WR, RESET_FLAGS_ADDR, 8'h0F);
		op(RD, RESET_FLAGS_ADDR, 8'h0F);
		op(WR, RESET_FLAGS_ADDR, 8'h00);
		for (int i = 0; i < NUM_COUNTERS; i++)
			op(PUT, COUNT_ADDR[i], COUNT_LAST[i]);
		for (int i = 0; i < NUM_COUNTERS; i++)
			op(GET, COUNT_ADDR[i], COUNT_LAST[i]);
		// Oscillator pins selected, adjustment output still off.
		op(WR, MODE_ADDR, 8'h01);
		op(RD, MODE_ADDR, 8'h01);
		idle(1);
		check({7'h00, osc_pin_select_out}, 8'h01);
		adj_ones(n);
		check(8'(n), 8'h00);
		// One second later every counter has wrapped through the cascade.
		idle(SEC + 64);
		for (int i = 0; i < NUM_COUNTERS; i++)
			op(GET, COUNT_ADDR[i], 8'h00);
		// Both carry flags are set and a read clears them.
		op(RD, FAST_CARRY_ADDR, 8'h01);
		op(RD, FAST_CARRY_ADDR, 8'h00);
		op(RD, SLOW_CARRY_ADDR, 8'h01);
		op(RD, SLOW_CARRY_ADDR, 8'h00);
		// Hold with adjustment output on; write-only bits read zero.
		op(WR, MODE_ADDR, 8'h0B);
		op(RD, MODE_ADDR, 8'h01);
		idle(1);
		adj_ones(n);
		check(8'(n > 0 && n < 64), 8'h01);
		idle(SEC);
		op(RD, FAST_CARRY_ADDR, 8'h01);
		idle(64);
		op(RD, FAST_CARRY_ADDR, 8'h00);
		op(GET, COUNT_ADDR[0], 8'h00);
		// Preset a cascade below the hours wrap while the divider is held.
		v = 8'(rnd() % COUNT_LAST[2]);
		op(WR, RESET_FLAGS_ADDR, 8'h07);
		op(WR, RESET_FLAGS_ADDR, 8'h00);
		op(PUT, COUNT_ADDR[0], COUNT_LAST[0]);
		op(PUT, COUNT_ADDR[1], COUNT_LAST[1]);
		op(PUT, COUNT_ADDR[2], v);
		// Released divider finishes the second from its half point.
		op(WR, MODE_ADDR, 8'h01);
		idle(SEC / 2 + 64);
		op(GET, COUNT_ADDR[0], 8'h00);
		op(GET, COUNT_ADDR[1], 8'h00);
		op(GET, COUNT_ADDR[2], v + 8'h01);
		op(GET, COUNT_ADDR[3], 8'h00);
		idle(4);
		final_report();
	end

	// Watchdog cuts a hang short well past the expected run time.
	initial
	begin
		repeat (4 * SEC) @(posedge clock_in);
		miscompares++;
		final_report();
	end

endmodule
